/* logic/avmm_responder.sv */
`timescale 1ns/1ns
module avmm_responder
  import nfc_irq_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic ce, // clock enable
  input wire bus_req_t req, // request as held by the master
  input wire logic [REG_W-1:0] rd_value, // selected register contents
  output logic waitrequest, // low for the one accepting cycle
  output logic [DATA_W-1:0] readdata, // valid while waitrequest is low
  output logic rd_done, // read completes at this edge
  output logic wr_done // write completes at this edge
);

  typedef struct packed {
    logic wait_n; // high while no request is being accepted
    logic [DATA_W-1:0] rdata;
  } rsp_state_t;

  rsp_state_t state_q;
  rsp_state_t state_d;

  // fixed latency: accept one cycle after the request shows, then
  // rearm; the data is frozen before the master samples it
  always_comb begin
    state_d = state_q;
    if (state_q.wait_n && (req.read || req.write)) begin
      state_d.wait_n = 1'b0;
      // writes leave the last read value standing on the bus
      if (req.read) begin
        state_d.rdata = {24'h00_0000, rd_value};
      end
    end else begin
      state_d.wait_n = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_q <= '{wait_n: 1'b1, rdata: RDATA_RST};
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign waitrequest = state_q.wait_n;
  assign readdata = state_q.rdata;
  // completion only counts on an enabled edge
  assign rd_done = ce && !state_q.wait_n && req.read;
  assign wr_done = ce && !state_q.wait_n && req.write;

endmodule

/* logic/nfc_irq_pkg.sv */
package nfc_irq_pkg;

  // register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned REG_W = 8;

  // register indices; byte address is four times the index
  localparam logic [4:0] IDX_MAIN_MASK = 5'h14;
  localparam logic [4:0] IDX_TIM_MASK = 5'h15;
  localparam logic [4:0] IDX_ERR_MASK = 5'h16;
  localparam logic [4:0] IDX_MAIN_FLAGS = 5'h17;
  localparam logic [4:0] IDX_TIM_FLAGS = 5'h18;
  localparam logic [4:0] IDX_ERR_FLAGS = 5'h19;

  // values after reset; the mask and flag values also after the set-default command
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  localparam logic [7:0] ALL_BITS = 8'hFF;

  // bits of the main flag and mask registers
  localparam int unsigned MAIN_OSC = 7;
  localparam int unsigned MAIN_WL = 6;
  localparam int unsigned MAIN_RXS = 5;
  localparam int unsigned MAIN_RXE = 4;
  localparam int unsigned MAIN_TXE = 3;
  localparam int unsigned MAIN_COL = 2;
  localparam int unsigned MAIN_TIM = 1;
  localparam int unsigned MAIN_ERR = 0;
  // bits 7..2 are detail sources; 1..0 are summaries, not maskable
  localparam logic [7:0] MAIN_SRC_BITS = 8'hFC;

  // main event strobes, one-cycle pulses from same-clock logic
  typedef struct packed {
    logic osc_stable;
    logic rx_start;
    logic rx_end;
    logic tx_end;
    logic bit_collision;
  } main_ev_t;

  // timer / field events in register bit order, 7 down to 0
  typedef struct packed {
    logic cmd_done;
    logic nrt_expire;
    logic gpt_expire;
    logic field_on;
    logic field_off;
    logic ca_collision;
    logic ca_guard_done;
    logic target_rate;
  } tim_ev_t;

  // error / wake-up events in register bit order, 7 down to 0
  typedef struct packed {
    logic crc;
    logic parity;
    logic soft_framing;
    logic hard_framing;
    logic wake_timer;
    logic wake_amp;
    logic wake_phase;
    logic wake_cap;
  } err_ev_t;

  // one register bus request as the master holds it
  typedef struct packed {
    logic read;
    logic write;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] writedata;
    logic [3:0] byteenable;
  } bus_req_t;

  // byte address decode, used by both the read mux and the side effects
  function automatic logic addr_hit(logic [ADDR_W-1:0] addr,
                                    logic [4:0] idx);
    addr_hit = (addr == {1'b0, idx, 2'b00});
  endfunction

endpackage

/* logic/nfc_reader_irq_aggregator.sv */
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ns
module nfc_reader_irq_aggregator
  import nfc_irq_pkg::*;
(
  input wire logic ref_clk, // system clock, 100 MHz
  input wire logic rstn, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes all state when low
  input wire logic set_default, // set-default command strobe
  input wire main_ev_t main_ev, // main event strobes
  input wire tim_ev_t tim_ev, // timer and field event strobes
  input wire err_ev_t err_ev, // error and wake-up event strobes
  input wire logic fifo_upper, // FIFO at or above upper water level
  input wire logic fifo_lower, // FIFO at or below lower water level
  input wire logic rx_active, // reception in progress
  input wire logic tx_active, // transmission in progress
  input wire logic [ADDR_W-1:0] avs_address, // byte address
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [DATA_W-1:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [DATA_W-1:0] avs_readdata, // read data
  output logic avs_waitrequest, // request stall
  output logic irq // interrupt request, active high
);

  typedef struct packed {
    logic [7:0] main_mask;
    logic [7:0] tim_mask;
    logic [7:0] err_mask;
    logic wl_level; // water-level condition seen last cycle
    logic irq;
  } top_state_t;

  top_state_t state_q;
  top_state_t state_d;

  bus_req_t req;
  logic [REG_W-1:0] rd_value;
  logic [DATA_W-1:0] rsp_rdata;
  logic rd_done;
  logic wr_done;
  logic wr_lane0;
  logic rd_main;
  logic rd_tim;
  logic rd_err;
  logic wl_now;
  logic [7:0] main_flags;
  logic [7:0] tim_flags;
  logic [7:0] err_flags;
  logic [7:0] main_set;
  logic [7:0] main_clr;
  logic [7:0] tim_clr;
  logic [7:0] err_clr;
  logic irq_now;

  // bundle the bus pins for the responder
  always_comb begin
    req.read = avs_read;
    req.write = avs_write;
    req.address = avs_address;
    req.writedata = avs_writedata;
    req.byteenable = avs_byteenable;
  end

  // read mux; unmapped addresses read as zero
  always_comb begin
    rd_value = 8'h00;
    if (addr_hit(avs_address, IDX_MAIN_MASK)) begin
      rd_value = state_q.main_mask;
    end else if (addr_hit(avs_address, IDX_TIM_MASK)) begin
      rd_value = state_q.tim_mask;
    end else if (addr_hit(avs_address, IDX_ERR_MASK)) begin
      rd_value = state_q.err_mask;
    end else if (addr_hit(avs_address, IDX_MAIN_FLAGS)) begin
      rd_value = main_flags;
    end else if (addr_hit(avs_address, IDX_TIM_FLAGS)) begin
      rd_value = tim_flags;
    end else if (addr_hit(avs_address, IDX_ERR_FLAGS)) begin
      rd_value = err_flags;
    end
  end

  avmm_responder u_bus (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .req(req),
    .rd_value(rd_value),
    .waitrequest(avs_waitrequest),
    .readdata(rsp_rdata),
    .rd_done(rd_done),
    .wr_done(wr_done)
  );

  assign avs_readdata = rsp_rdata;

  // completed reads of the flag registers drive the clear effects
  assign rd_main = rd_done && addr_hit(avs_address, IDX_MAIN_FLAGS);
  assign rd_tim = rd_done && addr_hit(avs_address, IDX_TIM_FLAGS);
  assign rd_err = rd_done && addr_hit(avs_address, IDX_ERR_FLAGS);
  assign wr_lane0 = wr_done && avs_byteenable[0];

  // water level condition: upper level in rx, lower level in tx
  // receive upper level
  assign wl_now = (rx_active && fifo_upper) || (tx_active && fifo_lower);

  // main flag sources; summaries follow any detail event, masked or
  // not; a main read clears the detail registers but leaves the summaries set
  // oscillator stable flag
  always_comb begin
    main_set = 8'h00;
    main_set[MAIN_OSC] = main_ev.osc_stable;
    main_set[MAIN_WL] = wl_now && !state_q.wl_level;
    main_set[MAIN_RXS] = main_ev.rx_start;
    main_set[MAIN_RXE] = main_ev.rx_end;
    main_set[MAIN_TXE] = main_ev.tx_end;
    main_set[MAIN_COL] = main_ev.bit_collision;
    main_set[MAIN_TIM] = |tim_ev;
    main_set[MAIN_ERR] = |err_ev;
  end

  // only the bits actually returned are cleared, so an event that
  // lands between sampling and completion is kept
  // main read clears 7..2
  always_comb begin
    main_clr = 8'h00;
    if (rd_main) begin
      main_clr = rsp_rdata[7:0] & MAIN_SRC_BITS;
    end
    main_clr[MAIN_TIM] = rd_tim;
    main_clr[MAIN_ERR] = rd_err;
  end

  // detail registers clear on a main register read
  // timer flags cleared
  assign tim_clr = rd_main ? ALL_BITS : 8'h00;
  assign err_clr = rd_main ? ALL_BITS : 8'h00;

  sticky_flag_bank u_main_flags (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .init(set_default),
    .set_i(main_set),
    .clr_i(main_clr),
    .flags_q(main_flags)
  );

  sticky_flag_bank u_tim_flags (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .init(set_default),
    .set_i(tim_ev),
    .clr_i(tim_clr),
    .flags_q(tim_flags)
  );

  sticky_flag_bank u_err_flags (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .init(set_default),
    .set_i(err_ev),
    .clr_i(err_clr),
    .flags_q(err_flags)
  );

  // request output: any unmasked flag; summaries are not maskable,
  // the detail masks already decide for their sources
  // request from unmasked flags
  assign irq_now = |(main_flags & MAIN_SRC_BITS & ~state_q.main_mask)
                || |(tim_flags & ~state_q.tim_mask)
                || |(err_flags & ~state_q.err_mask);

  // mask writes take effect at the completing edge only
  always_comb begin
    state_d = state_q;
    state_d.wl_level = wl_now;
    state_d.irq = irq_now;
    if (set_default) begin
      state_d.main_mask = MASK_RST;
      state_d.tim_mask = MASK_RST;
      state_d.err_mask = MASK_RST;
    end else if (wr_lane0) begin
      // main mask, bits 1..0 stay zero
      if (addr_hit(avs_address, IDX_MAIN_MASK)) begin
        state_d.main_mask = avs_writedata[7:0] & MAIN_SRC_BITS;
      end
      if (addr_hit(avs_address, IDX_TIM_MASK)) begin
        state_d.tim_mask = avs_writedata[7:0];
      end
      if (addr_hit(avs_address, IDX_ERR_MASK)) begin
        state_d.err_mask = avs_writedata[7:0];
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_q <= '{main_mask: MASK_RST, tim_mask: MASK_RST,
                   err_mask: MASK_RST, wl_level: 1'b0, irq: 1'b0};
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // irq lags the flags by one cycle so it leaves a flip-flop
  assign irq = state_q.irq;

endmodule

/* logic/sticky_flag_bank.sv */
`timescale 1ns/1ns
module sticky_flag_bank
  import nfc_irq_pkg::*;
(
  input wire logic ref_clk, // system clock
  input wire logic rstn, // synchronous reset, active low
  input wire logic ce, // clock enable, freezes the bank when low
  input wire logic init, // set-default command, clears all flags
  input wire logic [7:0] set_i, // event pulses, one per flag
  input wire logic [7:0] clr_i, // clear requests, one per flag
  output logic [7:0] flags_q // sticky flags
);

  typedef struct packed {
    logic [7:0] flags;
  } bank_state_t;

  bank_state_t state_q;
  bank_state_t state_d;

  // a set in the clearing cycle wins, so no event is lost
  always_comb begin
    state_d = state_q;
    if (init) begin
      state_d.flags = FLAG_RST;
    end else begin
      state_d.flags = (state_q.flags & ~clr_i) | set_i;
    end
  end

  // register the bank; ce freezes it
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      state_q <= '{flags: FLAG_RST};
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  assign flags_q = state_q.flags;

endmodule

/* tb/host_model.sv */
`timescale 1ns/1ns
module host_model
  import nfc_irq_pkg::*;
(
  input wire logic ref_clk, // clock
  output logic [ADDR_W-1:0] avs_address, // byte address
  output logic avs_read, // read request
  output logic avs_write, // write request
  output logic [DATA_W-1:0] avs_writedata, // write data
  input wire logic [DATA_W-1:0] avs_readdata, // read data
  input wire logic avs_waitrequest // stall
);
  // idle bus from time zero
  initial begin
    avs_address = 8'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
  end
  // one transfer, held until waitrequest is seen low at an edge
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a,
    input logic [7:0] wd, output logic [7:0] rd);
    @(posedge ref_clk);
    avs_address <= a;
    avs_read <= !w;
    avs_write <= w;
    avs_writedata <= {24'h000000, wd};
    // no cycle count assumed; the bench timeout ends a hung wait
    do begin
      @(posedge ref_clk);
    end while (avs_waitrequest !== 1'b0);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // released lines show no stale value
    avs_address <= ~a;
    avs_writedata <= ~{24'h000000, wd};
  endtask
endmodule

/* tb/irq_agg_checker.sv */
`timescale 1ns/1ns
module irq_agg_checker
  import nfc_irq_pkg::*;
(
  input wire logic ref_clk, // clock
  input wire logic rstn, // reset, active low
  input wire logic set_default, // set-default strobe
  input wire logic avs_read, // read request
  input wire logic avs_write, // write request
  input wire logic [ADDR_W-1:0] avs_address, // byte address
  input wire logic [DATA_W-1:0] avs_readdata, // read data
  input wire logic avs_waitrequest, // stall
  input wire logic irq // interrupt request
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // bus answers after exactly one wait cycle, for one cycle only
  chk_wait_one: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("request not accepted in time");
  chk_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("accept lasted more than one cycle");
  chk_rd_upper: assert property (!avs_waitrequest && avs_read
    |-> avs_readdata[31:8] == 24'h000000) else $error("upper bytes set");
  chk_unmapped_zero: assert property (!avs_waitrequest && avs_read &&
    (avs_address[1:0] != 2'h0 || avs_address < 8'h50 ||
    avs_address > 8'h64) |-> avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
  chk_mask_low: assert property (
    !avs_waitrequest && avs_read && avs_address == 8'h50
    |-> avs_readdata[1:0] == 2'h0) else $error("unused mask bits set");
  // read data may only move when a read is being accepted
  chk_rd_hold: assert property ($changed(avs_readdata)
    |-> !avs_waitrequest && avs_read) else $error("read data moved");
  chk_default_clr: assert property (set_default |-> ##2 !irq)
    else $error("irq after set-default");
  chk_reset_idle: assert property (disable iff (1'b0) !rstn
    |=> avs_waitrequest && !irq && avs_readdata == 32'h00000000)
    else $error("outputs not idle in reset");
endmodule
bind nfc_reader_irq_aggregator irq_agg_checker u_irq_agg_checker (
  .ref_clk(ref_clk),
  .rstn(rstn),
  .set_default(set_default),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_address(avs_address),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .irq(irq)
);

/* tb/testbench.sv */
`timescale 1ns/1ns
module testbench
  import nfc_irq_pkg::*;
();
  logic ref_clk, rstn, set_default, irq, avs_read, avs_write;
  logic fifo_upper, fifo_lower, rx_active, tx_active, avs_waitrequest;
  logic ce;
  logic [3:0] be;
  main_ev_t main_ev;
  tim_ev_t tim_ev;
  err_ev_t err_ev;
  logic [ADDR_W-1:0] avs_address;
  logic [DATA_W-1:0] avs_writedata, avs_readdata;
  int n_errors, total_checks, cyc;

  nfc_reader_irq_aggregator u_nfc_reader_irq_aggregator (
    .ref_clk(ref_clk), .rstn(rstn), .ce(ce), .set_default(set_default),
    .main_ev(main_ev), .tim_ev(tim_ev), .err_ev(err_ev),
    .fifo_upper(fifo_upper), .fifo_lower(fifo_lower),
    .rx_active(rx_active), .tx_active(tx_active),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  host_model u_host_model (
    .ref_clk(ref_clk), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

  task automatic finish_test;
    if (n_errors == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic rd(input logic [4:0] idx, input logic [7:0] exp);
    logic [7:0] d;
    u_host_model.xfer(1'b0, {1'b0, idx, 2'b00}, 8'h00, d);
    chk(d, exp);
  endtask
  task automatic wr(input logic [4:0] idx, input logic [7:0] v);
    logic [7:0] d;
    u_host_model.xfer(1'b1, {1'b0, idx, 2'b00}, v, d);
  endtask
  // one-cycle event pulse: 0 timer, 1 error, 2 main
  task automatic pulse(input int k, input logic [7:0] v);
    @(posedge ref_clk);
    if (k == 0) tim_ev <= v;
    else if (k == 1) err_ev <= v;
    else main_ev <= v[4:0];
    @(posedge ref_clk);
    tim_ev <= '0;
    err_ev <= '0;
    main_ev <= '0;
    repeat (2) @(posedge ref_clk);
  endtask
  // irq lags the flags, so let two edges land first
  task automatic irq_is(input logic e);
    repeat (2) @(posedge ref_clk);
    chk({7'h00, irq}, {7'h00, e});
  endtask
  task automatic sd;
    @(posedge ref_clk);
    set_default <= 1'b1;
    @(posedge ref_clk);
    set_default <= 1'b0;
  endtask
  task automatic wl(input logic rx, input logic tx);
    @(posedge ref_clk);
    rx_active <= rx;
    fifo_upper <= rx;
    tx_active <= tx;
    fifo_lower <= tx;
    repeat (2) @(posedge ref_clk);
  endtask

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // hang guard, far above the expected run length
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      finish_test;
    end
  end

  initial begin
    rstn = 1'b0;
    set_default = 1'b0;
    ce = 1'b1;
    be = 4'hF;
    main_ev = '0;
    tim_ev = '0;
    err_ev = '0;
    {fifo_upper, fifo_lower, rx_active, tx_active} = 4'h0;
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    for (int i = 20; i < 26; i++) rd(5'(i), 8'h00);
    rd(5'h00, 8'h00);
    wr(IDX_MAIN_MASK, 8'hFF);
    wr(IDX_TIM_MASK, 8'hFF);
    wr(IDX_ERR_MASK, 8'hFF);
    rd(IDX_MAIN_MASK, 8'hFC);
    rd(IDX_TIM_MASK, 8'hFF);
    rd(IDX_ERR_MASK, 8'hFF);
    // masked source still flags but keeps irq low
    pulse(0, 8'h80);
    irq_is(1'b0);
    wr(IDX_TIM_FLAGS, 8'h00);
    rd(IDX_TIM_FLAGS, 8'h80);
    rd(IDX_MAIN_FLAGS, 8'h00);
    sd;
    for (int i = 20; i < 23; i++) rd(5'(i), 8'h00);
    // every timer and error source, with summary clearing order
    for (int k = 0; k < 2; k++) begin
      for (int b = 0; b < 8; b++) begin
        logic [7:0] s;
        logic [7:0] v;
        logic [4:0] dr;
        s = k ? 8'h01 : 8'h02;
        v = 8'h01 << b;
        dr = k ? IDX_ERR_FLAGS : IDX_TIM_FLAGS;
        pulse(k, v);
        irq_is(1'b1);
        rd(IDX_MAIN_FLAGS, s);
        rd(IDX_MAIN_FLAGS, s);
        rd(dr, 8'h00);
        rd(IDX_MAIN_FLAGS, 8'h00);
        pulse(k, v);
        rd(dr, v);
        rd(IDX_MAIN_FLAGS, 8'h00);
        irq_is(1'b0);
      end
    end
    pulse(2, 8'h1F);
    irq_is(1'b1);
    rd(IDX_MAIN_FLAGS, 8'hBC);
    rd(IDX_MAIN_FLAGS, 8'h00);
    // water level: receive near full, then transmit near empty
    wl(1'b1, 1'b0);
    rd(IDX_MAIN_FLAGS, 8'h40);
    wl(1'b0, 1'b0);
    wl(1'b0, 1'b1);
    rd(IDX_MAIN_FLAGS, 8'h40);
    wl(1'b0, 1'b0);
    // set-default drops pending flags
    pulse(0, 8'hFF);
    sd;
    rd(IDX_MAIN_FLAGS, 8'h00);
    rd(IDX_TIM_FLAGS, 8'h00);
    // byte lane 0 off: the mask write is dropped
    be <= 4'hE;
    wr(IDX_TIM_MASK, 8'hFF);
    be <= 4'hF;
    rd(IDX_TIM_MASK, 8'h00);
    // clock enable low freezes state; an event in that time is lost
    pulse(1, 8'h80);
    ce <= 1'b0;
    pulse(0, 8'h40);
    ce <= 1'b1;
    rd(IDX_ERR_FLAGS, 8'h80);
    rd(IDX_MAIN_FLAGS, 8'h00);
    rd(IDX_TIM_FLAGS, 8'h00);
    // reset in mid-run drops masks and pending flags
    wr(IDX_ERR_MASK, 8'hFF);
    pulse(1, 8'h01);
    rstn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(IDX_ERR_MASK, 8'h00);
    rd(IDX_ERR_FLAGS, 8'h00);
    rd(IDX_MAIN_FLAGS, 8'h00);
    finish_test;
  end
endmodule
